// ===== rtl/data_memory_bank_select.sv
`timescale 1ns/1ps
module data_memory_bank_select
(
    // Clock and reset
    input  wire logic                                         sys_clk,
    input  wire logic                                         arst_n,
    input  wire logic                                         clk_en,
    // Access request from the sequencer
    input  wire bank_select_pkg::addr_mode_t                   access_mode,
    input  wire logic [7:0]                                   first_pointer_pair,
    input  wire logic [7:0]                                   second_pointer_pair,
    input  wire logic [7:0]                                   direct_offset,
    // Bank state writes
    input  wire logic                                         bank_select_primary_we,
    input  wire logic                                         bank_select_secondary_we,
    input  wire logic                                         flags_we,
    input  wire logic [2:0]                                   bank_wdata,
    input  wire logic                                         low_page_common_flag_wdata,
    input  wire logic                                         secondary_bank_enable_flag_wdata,
    // Bank state push/pop
    input  wire logic                                         push_bank_state,
    input  wire logic                                         pop_bank_state,
    input  wire logic [7:0]                                   bank_state_restore,
    // Stack pointer control
    input  wire logic                                         stack_save,
    input  wire logic                                         stack_restore,
    input  wire logic                                         stack_pointer_we,
    input  wire logic [7:0]                                   stack_pointer_wdata,
    // Outputs
    output logic [bank_select_pkg::ADDR_W-1:0]                data_addr,
    output logic                                              pair_access,
    output logic [7:0]                                        bank_state_save,
    output logic [7:0]                                        stack_pointer,
    output logic [2:0]                                        bank_select_primary,
    output logic [2:0]                                        bank_select_secondary,
    output logic                                              low_page_common_flag,
    output logic                                              secondary_bank_enable_flag
);
    import bank_select_pkg::*;

    logic [2:0] primary_reg;
    logic [2:0] primary_next;
    logic [2:0] secondary_reg;
    logic [2:0] secondary_next;
    logic       common_reg;
    logic       common_next;
    logic       enable_reg;
    logic       enable_next;
    logic [5:0] ptr_mid_reg;
    logic [5:0] ptr_mid_next;
    logic [2:0] chosen_select;
    logic [2:0] bank;
    logic [7:0] offset;

    // Bank state next values
    always_comb
    begin
        primary_next   = primary_reg;
        secondary_next = secondary_reg;
        common_next    = common_reg;
        enable_next    = enable_reg;
        if (pop_bank_state)
        begin
            // All four restored as one unit, plain writes lose
            primary_next   = bank_state_restore[PACK_PRIMARY_LSB +: BANK_W];
            secondary_next = bank_state_restore[PACK_SECONDARY_LSB +: BANK_W];
            common_next    = bank_state_restore[PACK_COMMON_POS];
            enable_next    = bank_state_restore[PACK_ENABLE_POS];
        end
        else
        begin
            if (bank_select_primary_we)
                primary_next = bank_wdata;
            if (bank_select_secondary_we)
                secondary_next = bank_wdata;
            if (flags_we)
            begin
                common_next = low_page_common_flag_wdata;
                enable_next = secondary_bank_enable_flag_wdata;
            end
        end
    end

    // Bank state registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            primary_reg   <= BANK_REG_RESET;
            secondary_reg <= BANK_REG_RESET;
            common_reg    <= FLAG_RESET;
            enable_reg    <= FLAG_RESET;
        end
        else if (clk_en)
        begin
            primary_reg   <= primary_next;
            secondary_reg <= secondary_next;
            common_reg    <= common_next;
            enable_reg    <= enable_next;
        end
    end

    // Stack pointer middle counter, load beats counting
    always_comb
    begin
        ptr_mid_next = ptr_mid_reg;
        if (stack_pointer_we)
            ptr_mid_next = stack_pointer_wdata[6:1];
        else if (stack_save && !stack_restore)
            ptr_mid_next = ptr_mid_reg - STACK_PTR_STEP;
        else if (stack_restore && !stack_save)
            ptr_mid_next = ptr_mid_reg + STACK_PTR_STEP;
    end

    // Stack pointer middle register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ptr_mid_reg <= STACK_PTR_RESET[6:1];
        else if (clk_en)
            ptr_mid_reg <= ptr_mid_next;
    end

    // Bank and offset decode
    always_comb
    begin
        chosen_select = enable_reg ? secondary_reg : primary_reg;
        bank          = primary_reg[0] ? BANK_SEVEN : BANK_ZERO;
        offset        = first_pointer_pair;
        unique case (access_mode)
            MODE_FIRST_PAIR:
            begin
                bank   = primary_reg[0] ? BANK_SEVEN : BANK_ZERO;
                offset = first_pointer_pair;
            end
            MODE_SECOND_PAIR:
            begin
                bank   = chosen_select[0] ? BANK_SEVEN : BANK_ZERO;
                offset = second_pointer_pair;
            end
            MODE_DIRECT:
            begin
                offset = direct_offset;
                if (common_reg && direct_offset <= LOW_PAGE_LAST)
                    bank = BANK_ZERO;
                else
                    bank = chosen_select[0] ? BANK_SEVEN : BANK_ZERO;
            end
            MODE_STACK:
            begin
                bank   = BANK_SEVEN;
                offset = {1'b1, ptr_mid_reg, 1'b0};
            end
        endcase
    end

    // Outputs, decode combinational for next access
    assign data_addr                  = {bank, offset};
    assign pair_access                = (access_mode == MODE_STACK);
    assign bank_state_save            = {enable_reg, common_reg, secondary_reg, primary_reg};
    assign stack_pointer              = {1'b1, ptr_mid_reg, 1'b1};
    assign bank_select_primary        = primary_reg;
    assign bank_select_secondary      = secondary_reg;
    assign low_page_common_flag       = common_reg;
    assign secondary_bank_enable_flag = enable_reg;

    // Bank choice per addressing mode
    AST_FIRST_PAIR_PRIMARY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_FIRST_PAIR
        |-> data_addr[10:8] == (primary_reg[0] ? BANK_SEVEN : BANK_ZERO))
        else $error("First-pair bank not from primary register");
    AST_ENABLE_SELECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_SECOND_PAIR && enable_reg
        |-> data_addr[10:8] == (secondary_reg[0] ? BANK_SEVEN : BANK_ZERO))
        else $error("Second-pair bank not from secondary register");
    AST_PRIMARY_WHEN_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_SECOND_PAIR && !enable_reg
        |-> data_addr[10:8] == (primary_reg[0] ? BANK_SEVEN : BANK_ZERO))
        else $error("Second-pair bank not from primary register");
    AST_COMMON_LOW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_DIRECT && common_reg && !direct_offset[7]
        |-> data_addr == {BANK_ZERO, direct_offset})
        else $error("Common low page not bank 0");
    AST_COMMON_HIGH: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_DIRECT && direct_offset[7]
        |-> data_addr[10:8] == ((enable_reg ? secondary_reg[0] : primary_reg[0]) ? BANK_SEVEN : BANK_ZERO))
        else $error("Direct upper half bank wrong");
    AST_STACK_BANK: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_STACK
        |-> data_addr[10:8] == BANK_SEVEN && data_addr[0] == 1'b0 && pair_access)
        else $error("Stack access not in bank 7");
    AST_PAIR_FLAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode != MODE_STACK |-> !pair_access)
        else $error("Pair access outside stack mode");

    // Offsets per addressing mode
    AST_FIRST_PAIR_OFFSET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_FIRST_PAIR |-> data_addr[7:0] == first_pointer_pair)
        else $error("First-pair offset wrong");
    AST_SECOND_PAIR_OFFSET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_SECOND_PAIR |-> data_addr[7:0] == second_pointer_pair)
        else $error("Second-pair offset wrong");
    AST_DIRECT_OFFSET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_DIRECT |-> data_addr[7:0] == direct_offset)
        else $error("Direct offset wrong");

    // Stack pointer behaviour
    AST_PTR_ENDS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        stack_pointer[7] && stack_pointer[0])
        else $error("Stack pointer end bits not one");
    AST_PTR_DOWN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && stack_save && !stack_restore && !stack_pointer_we
        |=> stack_pointer[6:1] == $past(stack_pointer[6:1]) - 6'h01)
        else $error("Stack pointer did not count down");
    AST_PTR_UP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && stack_restore && !stack_save && !stack_pointer_we
        |=> stack_pointer[6:1] == $past(stack_pointer[6:1]) + 6'h01)
        else $error("Stack pointer did not count up");

    // Bank state storage
    AST_POP_ALL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && pop_bank_state |=> bank_state_save == $past(bank_state_restore))
        else $error("Pop did not restore bank state");
    AST_WRITE_FULL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clk_en && bank_select_secondary_we && !pop_bank_state
        |=> bank_select_secondary == $past(bank_wdata))
        else $error("Secondary register lost written bits");
    AST_HOLD_FROZEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !clk_en |=> $stable(bank_state_save) && $stable(stack_pointer))
        else $error("State changed while clock enable low");

    // Main scenarios reached
    COV_COMMON_DIRECT: cover property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_DIRECT && common_reg && !direct_offset[7]);
    COV_SECONDARY_PAIR: cover property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_SECOND_PAIR && enable_reg && secondary_reg[0]);
    COV_SECONDARY_DIRECT_HIGH: cover property (@(posedge sys_clk) disable iff (!arst_n)
        access_mode == MODE_DIRECT && direct_offset[7] && enable_reg);
    COV_PUSH_POP: cover property (@(posedge sys_clk) disable iff (!arst_n)
        push_bank_state ##[1:20] pop_bank_state);
endmodule

// ===== rtl/bank_select_pkg.sv
package bank_select_pkg;
    localparam int BANK_W = 3;
    localparam int OFFS_W = 8;
    localparam int ADDR_W = BANK_W + OFFS_W;
    localparam logic [2:0] BANK_ZERO  = 3'h0;
    localparam logic [2:0] BANK_SEVEN = 3'h7;
    localparam logic [7:0] LOW_PAGE_LAST = 8'h7F;
    localparam logic [2:0] BANK_REG_RESET  = 3'h0;
    localparam logic       FLAG_RESET      = 1'b0;
    localparam logic [7:0] STACK_PTR_RESET = 8'hFF;
    localparam logic [5:0] STACK_PTR_STEP  = 6'h01;
    localparam int BANK_STATE_W = 8;
    // Bit positions inside the packed bank state
    localparam int PACK_PRIMARY_LSB   = 0;
    localparam int PACK_SECONDARY_LSB = 3;
    localparam int PACK_COMMON_POS    = 6;
    localparam int PACK_ENABLE_POS    = 7;

    typedef enum logic [1:0]
    {
        MODE_FIRST_PAIR,
        MODE_SECOND_PAIR,
        MODE_DIRECT,
        MODE_STACK
    } addr_mode_t;
endpackage

// ===== testbench/access_sequencer_model.sv
`timescale 1ns/1ps
module access_sequencer_model
(
    // Clock
    input  wire logic       sys_clk,
    // Pulsed controls and their shared data
    output logic      [7:0] ctl,
    output logic      [7:0] dat
);
    // Idle until a request is issued
    initial
    begin
        ctl = 8'h00;
        dat = 8'h00;
    end
    // One-cycle request, changed only at falling edges
    task automatic issue(input logic [7:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        ctl = c;
        dat = d;
        @(negedge sys_clk);
        ctl = 8'h00;
        dat = ~d; // Released data stops showing the last value
    endtask
endmodule

// ===== testbench/data_memory_bank_select_tb.sv
`timescale 1ns/1ps
module data_memory_bank_select_tb;
    import bank_select_pkg::*;
    logic              sys_clk, arst_n, clk_en;
    addr_mode_t        mode;
    logic [7:0]        oa, ob, od, ctl, dat, st, ptr;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        b0, b1;
    logic              pair, com, en;
    int                bad_count, total_checks;
    data_memory_bank_select u_data_memory_bank_select (.sys_clk(sys_clk), .arst_n(arst_n),
        .clk_en(clk_en), .access_mode(mode), .first_pointer_pair(oa), .second_pointer_pair(ob),
        .direct_offset(od), .bank_select_primary_we(ctl[0]), .bank_select_secondary_we(ctl[1]),
        .flags_we(ctl[2]), .bank_wdata(dat[2:0]), .low_page_common_flag_wdata(dat[0]),
        .secondary_bank_enable_flag_wdata(dat[1]), .push_bank_state(ctl[3]),
        .pop_bank_state(ctl[4]), .bank_state_restore(dat), .stack_save(ctl[5]),
        .stack_restore(ctl[6]), .stack_pointer_we(ctl[7]), .stack_pointer_wdata(dat),
        .data_addr(addr), .pair_access(pair), .bank_state_save(st), .stack_pointer(ptr),
        .bank_select_primary(b0), .bank_select_secondary(b1), .low_page_common_flag(com),
        .secondary_bank_enable_flag(en));
    access_sequencer_model u_access_sequencer_model (.sys_clk(sys_clk), .ctl(ctl), .dat(dat));
    // Free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Physical bank of a register value
    function automatic logic [2:0] dec(input logic [2:0] v);
        return v[0] ? BANK_SEVEN : BANK_ZERO;
    endfunction
    // Only the used offset source carries o
    task automatic probe(input addr_mode_t m, input logic [7:0] o, input logic [2:0] bk);
        @(negedge sys_clk);
        mode = m;
        oa = (m == MODE_FIRST_PAIR) ? o : ~o;
        ob = (m == MODE_SECOND_PAIR) ? o : ~o;
        od = (m == MODE_DIRECT) ? o : ~o;
        #1;
        chk("data_addr", {bk, o}, addr);
        chk("pair_access", 16'(m == MODE_STACK), pair);
    endtask
    // Asynchronous reset values
    task automatic test_reset();
        @(negedge sys_clk);
        arst_n = 1'b0;
        #1;
        chk("bank_regs", 16'h0000, {b0, b1, com, en});
        chk("stack_pointer", 8'hFF, ptr);
        @(negedge sys_clk);
        arst_n = 1'b1;
        probe(MODE_STACK, 8'hFE, BANK_SEVEN);
    endtask
    // Every register value against every flag setting
    task automatic test_modes();
        logic [2:0] bs;
        for (int v = 0; v < 8; v++)
        begin
            u_access_sequencer_model.issue(8'h01, 8'(v));
            u_access_sequencer_model.issue(8'h02, 8'(7 - v));
            chk("primary", 16'(v), b0);
            chk("secondary", 16'(7 - v), b1);
            for (int f = 0; f < 4; f++)
            begin
                u_access_sequencer_model.issue(8'h04, 8'(f));
                bs = f[1] ? dec(3'(7 - v)) : dec(3'(v));
                probe(MODE_FIRST_PAIR, 8'h5A, dec(3'(v)));
                probe(MODE_SECOND_PAIR, 8'hA5, bs);
                probe(MODE_DIRECT, 8'h80, bs);
                probe(MODE_DIRECT, 8'h7F, f[0] ? BANK_ZERO : bs);
                probe(MODE_STACK, 8'hFE, BANK_SEVEN);
            end
        end
    endtask
    // Counting, loads and the fixed end bits
    task automatic test_stack();
        u_access_sequencer_model.issue(8'h20, 8'h00);
        chk("stack_pointer", 8'hFD, ptr);
        probe(MODE_STACK, 8'hFC, BANK_SEVEN);
        chk("pair_access", 1'b1, pair);
        u_access_sequencer_model.issue(8'h80, 8'h00);
        chk("stack_pointer", 8'h81, ptr);
        u_access_sequencer_model.issue(8'hA0, 8'h54);
        chk("stack_pointer", 8'hD5, ptr);
        u_access_sequencer_model.issue(8'h40, 8'h00);
        chk("stack_pointer", 8'hD7, ptr);
        u_access_sequencer_model.issue(8'h60, 8'h00);
        chk("stack_pointer", 8'hD7, ptr);
    endtask
    // Bank state saved and restored as one unit
    task automatic test_push_pop();
        u_access_sequencer_model.issue(8'h01, 8'h05);
        u_access_sequencer_model.issue(8'h02, 8'h02);
        u_access_sequencer_model.issue(8'h0C, 8'h03);
        chk("bank_state_save", 8'hD5, st);
        u_access_sequencer_model.issue(8'h10, 8'h4E);
        chk("bank_regs", 16'h0039, {b1, b0, en, com});
        u_access_sequencer_model.issue(8'h12, 8'h02);
        chk("bank_regs", 16'h0008, {b1, b0, en, com});
        @(negedge sys_clk);
        clk_en = 1'b0;
        u_access_sequencer_model.issue(8'h01, 8'h03);
        chk("primary", 16'h0002, b0);
        clk_en = 1'b1;
    endtask
    // Verdict and end of run
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #200000;
        bad_count++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        mode = MODE_FIRST_PAIR;
        {oa, ob, od} = 24'h000000;
        repeat (5) @(posedge sys_clk);
        test_reset();
        test_modes();
        test_stack();
        test_push_pop();
        test_reset();
        give_verdict();
    end
endmodule
